/* File: logic/aips_top.sv */
// input sample port: capture, range-code scaling, lane tagging, buffered hand-off
// assumes: pins synchronous to mclk_i, registers written over the internal register port
`timescale 1ns/1ps
`default_nettype none
`include "aips_regs.svh"

// Notes on behaviour
// - capture mantissa, range and lane together each edge with ce_i high
// - mantissa is signed two's complement
// - range code is unsigned zero to seven
// - three input modes chosen at register 300h
// - offset lives in bits 7..5 of 305h
// - invert flag in bit 4 of 305h
// - clear invert: shift by range plus offset mod 8
// - set invert: shift seven minus range plus offset
// - complex mode: lane select marks I versus Q
// - single real: lane select is active-high enable
// - diversity: first sample after each lane change only
module aips_top #(
    parameter int MAN_W = 16,
    parameter int RNG_W = 3
) (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_i,
    input  wire logic                    ce_i,
    input  wire logic [MAN_W-1:0]        in_mantissa_i,
    input  wire logic [RNG_W-1:0]        in_range_i,
    input  wire logic                    in_lane_sel_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    input  wire logic [`AIPS_ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    output var  logic [7:0]              reg_rdata_o,
    output var  logic                    out_valid_o,
    output var  logic [MAN_W-1:0]        out_sample_o,
    output var  logic                    out_lane_o,
    input  wire logic                    out_ready_i,
    output var  logic                    in_ready_o,
    output var  logic                    overflow_o,
    output var  aips_pkg::aips_mode_t    mode_o
);
    import aips_pkg::*;

    // shifter and offset field are three bits wide; refused while elaborating
    if (RNG_W != 3) begin : g_bad_rng
        $error("aips_top: RNG_W must be 3");
    end
    if (MAN_W < 8) begin : g_bad_man
        $error("aips_top: MAN_W must be at least 8");
    end

    // shift amount, wraps modulo 8 by its 3-bit width
    function automatic logic [2:0] shift_amount(input logic [2:0] rng,
                                                input logic [2:0] off,
                                                input logic       inv);
        logic [2:0] base;
        base = inv ? (`AIPS_INV_REF - rng) : rng;
        return 3'(base + off);
    endfunction

    // capture stage
    logic signed [MAN_W-1:0] cap_man_q, cap_man_d;   // captured mantissa
    logic [RNG_W-1:0]        cap_rng_q, cap_rng_d;   // captured range code
    logic                    cap_sel_q, cap_sel_d;   // captured lane select
    logic                    prv_sel_q, prv_sel_d;   // lane select one capture earlier
    // scaled stage, feeds the buffer
    logic                    st_valid_q, st_valid_d;
    logic signed [MAN_W-1:0] st_data_q, st_data_d;
    logic                    st_lane_q, st_lane_d;
    // control registers
    aips_mode_t              mode_q, mode_d;
    logic [2:0]              off_q, off_d;
    logic                    inv_q, inv_d;
    logic                    ovf_q, ovf_d;
    logic [7:0]              rdata_q, rdata_d;
    // combinational helpers
    logic                    accept;
    logic                    lane;
    logic [2:0]              shamt;
    logic                    buf_ready;
    logic                    buf_valid;
    logic [MAN_W:0]          buf_data;
    logic                    wr_mode;
    logic                    wr_adj;

    // next values of the capture and scaled stages
    always_comb begin
        cap_man_d = in_mantissa_i;
        cap_rng_d = in_range_i;
        cap_sel_d = in_lane_sel_i;
        prv_sel_d = cap_sel_q;
        shamt     = shift_amount(cap_rng_q, off_q, inv_q);
        case (mode_q)
            AIPS_SINGLE_REAL: begin
                accept = cap_sel_q;
                lane   = 1'b1;
            end
            AIPS_DIVERSITY: begin
                accept = cap_sel_q ^ prv_sel_q;
                lane   = cap_sel_q;
            end
            AIPS_COMPLEX: begin
                // high lane select is in-phase, low is quadrature
                accept = cap_sel_q ^ prv_sel_q;
                lane   = cap_sel_q;
            end
            default: begin
                accept = 1'b0;
                lane   = 1'b0;
            end
        endcase
        st_valid_d = accept;
        st_data_d  = cap_man_q >>> shamt;
        st_lane_d  = lane;
    end

    // register only
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cap_man_q  <= '0;
            cap_rng_q  <= '0;
            cap_sel_q  <= 1'b0;
            prv_sel_q  <= 1'b0;
            st_valid_q <= 1'b0;
            st_data_q  <= '0;
            st_lane_q  <= 1'b0;
        end else if (ce_i) begin
            cap_man_q  <= cap_man_d;
            cap_rng_q  <= cap_rng_d;
            cap_sel_q  <= cap_sel_d;
            prv_sel_q  <= prv_sel_d;
            st_valid_q <= st_valid_d;
            st_data_q  <= st_data_d;
            st_lane_q  <= st_lane_d;
        end
    end

    // register port decode; the ADC cannot stall, so a full buffer drops and flags
    always_comb begin
        wr_mode = reg_wr_i && (reg_addr_i == `AIPS_ADDR_MODE);
        wr_adj  = reg_wr_i && (reg_addr_i == `AIPS_ADDR_ADJ);
        mode_d  = mode_q;
        off_d   = off_q;
        inv_d   = inv_q;
        ovf_d   = ovf_q;
        if (wr_mode) begin
            // reserved code 11 is ignored, mode keeps its value
            if (reg_wdata_i[`AIPS_MODE_MSB:`AIPS_MODE_LSB] != 2'h3) begin
                mode_d = aips_mode_t'(reg_wdata_i[`AIPS_MODE_MSB:`AIPS_MODE_LSB]);
            end
            if (reg_wdata_i[`AIPS_OVF_BIT]) begin
                ovf_d = 1'b0;
            end
        end
        if (wr_adj) begin
            off_d = reg_wdata_i[`AIPS_OFF_MSB:`AIPS_OFF_LSB];
            inv_d = reg_wdata_i[`AIPS_INV_BIT];
        end
        // set wins over a clear in the same cycle
        if (st_valid_q && !buf_ready) begin
            ovf_d = 1'b1;
        end
        rdata_d = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == `AIPS_ADDR_MODE) begin
                rdata_d[`AIPS_MODE_MSB:`AIPS_MODE_LSB] = mode_q;
                rdata_d[`AIPS_OVF_BIT]                 = ovf_q;
            end else if (reg_addr_i == `AIPS_ADDR_ADJ) begin
                rdata_d[`AIPS_OFF_MSB:`AIPS_OFF_LSB] = off_q;
                rdata_d[`AIPS_INV_BIT]               = inv_q;
            end
        end
    end

    // register only
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mode_q  <= aips_mode_t'(`AIPS_MODE_RST);
            off_q   <= `AIPS_OFF_RST;
            inv_q   <= `AIPS_INV_RST;
            ovf_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else if (ce_i) begin
            mode_q  <= mode_d;
            off_q   <= off_d;
            inv_q   <= inv_d;
            ovf_q   <= ovf_d;
            rdata_q <= rdata_d;
        end
    end

    // hand-off buffer: a stall downstream costs no word while it has room
    aips_skid #(
        .W (MAN_W + 1)
    ) u_skid (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_valid_i  (st_valid_q),
        .in_data_i   ({st_lane_q, st_data_q}),
        .in_ready_o  (buf_ready),
        .out_valid_o (buf_valid),
        .out_data_o  (buf_data),
        .out_ready_i (out_ready_i)
    );

    assign out_valid_o  = buf_valid;
    assign out_sample_o = buf_data[MAN_W-1:0];
    assign out_lane_o   = buf_data[MAN_W];
    assign in_ready_o   = buf_ready;
    assign overflow_o   = ovf_q;
    assign mode_o       = mode_q;
    assign reg_rdata_o  = rdata_q;

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_capture;
        ce_i |=> (cap_man_q == $past(in_mantissa_i)) && (cap_rng_q == $past(in_range_i))
            && (cap_sel_q == $past(in_lane_sel_i));
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost a pin");

    property p_sign;
        (ce_i && accept && cap_man_q[MAN_W-1]) |=> st_data_q[MAN_W-1];
    endproperty
    a_sign: assert property (p_sign) else $error("sign not extended");

    property p_shift_plain;
        (ce_i && accept && !inv_q) |=>
            st_data_q == ($past(cap_man_q) >>> 3'($past(cap_rng_q) + $past(off_q)));
    endproperty
    a_shift_plain: assert property (p_shift_plain) else $error("plain shift wrong");

    property p_shift_inv;
        (ce_i && accept && inv_q) |=>
            st_data_q == ($past(cap_man_q) >>> 3'(3'h7 - $past(cap_rng_q) + $past(off_q)));
    endproperty
    a_shift_inv: assert property (p_shift_inv) else $error("inverted shift wrong");

    property p_mode_reserved;
        (ce_i && wr_mode && reg_wdata_i[1:0] == 2'h3) |=> $stable(mode_q);
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("mode took code 3");

    property p_adj_write;
        (ce_i && wr_adj) |=> (off_q == $past(reg_wdata_i[7:5]))
            && (inv_q == $past(reg_wdata_i[4]));
    endproperty
    a_adj_write: assert property (p_adj_write) else $error("adjust write lost");

    property p_enable;
        (ce_i && mode_q == AIPS_SINGLE_REAL) |=> st_valid_q == $past(cap_sel_q);
    endproperty
    a_enable: assert property (p_enable) else $error("enable misread");

    property p_first_only;
        (ce_i && mode_q == AIPS_DIVERSITY && cap_sel_q == prv_sel_q) |=> !st_valid_q;
    endproperty
    a_first_only: assert property (p_first_only) else $error("repeat sample taken");

    property p_iq_tag;
        (ce_i && mode_q == AIPS_COMPLEX && cap_sel_q != prv_sel_q) |=>
            st_valid_q && (st_lane_q == $past(cap_sel_q));
    endproperty
    a_iq_tag: assert property (p_iq_tag) else $error("I/Q tag wrong");

    property p_hold_out;
        (out_valid_o && !out_ready_i && ce_i) |=> out_valid_o && $stable(out_sample_o)
            && $stable(out_lane_o);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("stalled word changed");

    c_div_pair:  cover property (mode_q == AIPS_DIVERSITY && st_valid_q ##1 st_valid_q);
    c_stall:     cover property (out_valid_o && !out_ready_i ##1 !in_ready_o);
    c_overflow:  cover property (!overflow_o ##1 overflow_o);
    c_inv_shift: cover property (accept && inv_q && shamt == 3'h0);
endmodule
`default_nettype wire

/* File: logic/aips_regs.svh */
// register map, field positions, reset values and fixed figures of the input port scaler
// assumes: included by bare name from the top-level design file only
`ifndef AIPS_REGS_SVH
`define AIPS_REGS_SVH

`define AIPS_ADDR_W          10
`define AIPS_ADDR_MODE       10'h300
`define AIPS_ADDR_ADJ        10'h305
`define AIPS_MODE_LSB        0
`define AIPS_MODE_MSB        1
`define AIPS_OVF_BIT         7
`define AIPS_OFF_LSB         5
`define AIPS_OFF_MSB         7
`define AIPS_INV_BIT         4
`define AIPS_MODE_RST        2'h0
`define AIPS_OFF_RST         3'h0
`define AIPS_INV_RST         1'h0
`define AIPS_INV_REF         3'h7
`define AIPS_MAX_RATE_MSPS   67

`endif

/* File: logic/aips_pkg.sv */
// types shared by the input port scaler files
// assumes: the register header sits next to it
package aips_pkg;
    // input mode, stored in the low bits of the mode register
    typedef enum logic [1:0] {
        AIPS_SINGLE_REAL = 2'b00,
        AIPS_DIVERSITY   = 2'b01,
        AIPS_COMPLEX     = 2'b10
    } aips_mode_t;
endpackage

/* File: logic/aips_skid.sv */
// two-entry skid buffer between the scaler and the frequency translator
// assumes: one clock, synchronous active-high reset, clock enable freezes it
`timescale 1ns/1ps
`default_nettype none
module aips_skid #(
    parameter int W = 17
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output var  logic         in_ready_o,
    output var  logic         out_valid_o,
    output var  logic [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    import aips_pkg::*;

    // refuse a width the buffer cannot hold, while elaborating
    if (W < 1) begin : g_bad_w
        $error("aips_skid: W must be positive");
    end

    logic         ov_q, ov_d;   // output entry holds a word
    logic [W-1:0] od_q, od_d;   // output entry word
    logic         sv_q, sv_d;   // skid entry holds a word
    logic [W-1:0] sd_q, sd_d;   // skid entry word
    logic         push;         // word taken from the filling side
    logic         rdy_q, rdy_d; // room flag in its own flop, so ready leaves a register

    // next state: output entry refills from skid first, keeping order
    always_comb begin
        ov_d = ov_q;
        od_d = od_q;
        sv_d = sv_q;
        sd_d = sd_q;
        push = in_valid_i && !sv_q;
        if (!ov_q || out_ready_i) begin
            if (sv_q) begin
                // skid full means no push this cycle
                ov_d = 1'b1;
                od_d = sd_q;
                sv_d = 1'b0;
            end else begin
                ov_d = push;
                if (push) begin
                    od_d = in_data_i;
                end
            end
        end else if (push) begin
            // receiver stalled: park the word instead of losing it
            sv_d = 1'b1;
            sd_d = in_data_i;
        end
        // room while the skid entry will be empty
        rdy_d = !sv_d;
    end

    // registers only
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ov_q <= 1'b0;
            od_q <= '0;
            sv_q <= 1'b0;
            sd_q <= '0;
            rdy_q <= 1'b1;
        end else if (ce_i) begin
            ov_q <= ov_d;
            od_q <= od_d;
            sv_q <= sv_d;
            sd_q <= sd_d;
            rdy_q <= rdy_d;
        end
    end

    assign in_ready_o  = rdy_q;  // straight from the ready flop
    assign out_valid_o = ov_q;
    assign out_data_o  = od_q;
endmodule
`default_nettype wire

/* File: dv/aips_adc_model.sv */
// behavioural converter that feeds the input port scaler
// assumes: bench sets send/code/range/lane just after the rising edge
`timescale 1ns/1ps
`default_nettype none
module aips_adc_model #(
    parameter int ADC_W = 12
) (
    input  wire logic             mclk_i,
    input  wire logic             send_i,  // new word this edge
    input  wire logic             hold_i,  // lane stays between words
    input  wire logic [ADC_W-1:0] code_i,
    input  wire logic [2:0]       range_i,
    input  wire logic             lane_i,
    output var  logic [15:0]      mant_o,
    output var  logic [2:0]       range_o,
    output var  logic             lane_o
);
    // pins start quiet
    initial begin
        mant_o  = 16'h0000;
        range_o = 3'h0;
        lane_o  = 1'b0;
    end
    // pins move only on the rising edge
    always @(posedge mclk_i) begin
        if (send_i) begin
            // narrow word sits at the top, low bits zero
            mant_o  <= {code_i, {(16-ADC_W){1'b0}}};
            range_o <= range_i;
            lane_o  <= lane_i;
        end else begin
            // no word: data is junk, so it changes every cycle
            mant_o  <= ~mant_o;
            range_o <= ~range_o;
            // enable drops between words unless lane must stay
            lane_o  <= hold_i ? lane_o : 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: dv/aips_top_tb.sv */
// self-checking bench for the input port scaler
// assumes: design under logic/, converter model in dv/
`timescale 1ns/1ps
`default_nettype none
module aips_top_tb;
    import aips_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        send = 1'b0;    // converter strobe
    logic        hold = 1'b0;    // lane kept between words
    logic        lane = 1'b0;
    logic [11:0] code = 12'h000;
    logic [2:0]  rng = 3'h0;
    logic [15:0] mant;
    logic [2:0]  rpin;
    logic        lpin;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [9:0]  addr_s = 10'h000;
    logic [7:0]  wdata_s = 8'h00;
    logic [7:0]  rdata;
    logic        out_valid;
    logic [15:0] out_sample;
    logic        out_lane;
    logic        out_ready = 1'b1;
    logic        ce = 1'b1;      // clock enable into the design
    logic        in_ready;
    logic        overflow;
    aips_mode_t  mode;
    logic [16:0] got_q[$];       // words taken downstream
    logic [16:0] exp_q[$];       // words the rules predict
    int          errors = 0;
    int          check_count = 0;

    // 250 MHz clock
    initial forever #2 mclk_i = ~mclk_i;

    aips_adc_model ADC (.mclk_i(mclk_i), .send_i(send), .hold_i(hold), .code_i(code),
        .range_i(rng), .lane_i(lane), .mant_o(mant), .range_o(rpin), .lane_o(lpin));

    aips_top DUT (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce), .in_mantissa_i(mant),
        .in_range_i(rpin), .in_lane_sel_i(lpin), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_addr_i(addr_s), .reg_wdata_i(wdata_s), .reg_rdata_o(rdata),
        .out_valid_o(out_valid), .out_sample_o(out_sample), .out_lane_o(out_lane),
        .out_ready_i(out_ready), .in_ready_o(in_ready), .overflow_o(overflow),
        .mode_o(mode));

    // collect every word handed downstream
    always @(posedge mclk_i) begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
            got_q.push_back({out_lane, out_sample});
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // one-cycle strobes, entered just after an edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        addr_s = a;
        wdata_s = d;
        wr_s = 1'b1;
        @(posedge mclk_i);
        #1 wr_s = 1'b0;
    endtask

    // read data stands for the cycle after the read edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        addr_s = a;
        rd_s = 1'b1;
        @(posedge mclk_i);
        #1 rd_s = 1'b0;
        d = rdata;
    endtask

    task automatic put(input logic [11:0] c, input logic [2:0] r, input logic l);
        send = 1'b1;
        code = c;
        rng = r;
        lane = l;
        @(posedge mclk_i);
        #1;
    endtask

    task automatic idle(input int n);
        send = 1'b0;
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // expected word: 3-bit wrap of the shift count is the mod 8
    function automatic logic [16:0] scl(input logic [11:0] c, input logic [2:0] r,
                                        input logic [2:0] off, input logic inv,
                                        input logic l);
        logic [2:0] sh;
        sh = inv ? 3'h7 - r + off : r + off;
        return {l, $signed({c, 4'h0}) >>> sh};
    endfunction

    // compare predicted and taken words, then empty both lists
    task automatic drain(input string what);
        idle(12);
        chk(what, 17'(exp_q.size()), 17'(got_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0)
            chk(what, exp_q.pop_front(), got_q.pop_front());
        exp_q.delete();
        got_q.delete();
        $display("test %s done", what);
    endtask

    // hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        complete_run();
    end

    initial begin
        logic [7:0]  v;
        logic [2:0]  off;
        logic [11:0] c;
        repeat (20) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        rd(10'h300, v);
        chk("mode reg", 17'h00, 17'(v));
        rd(10'h305, v);
        chk("adjust reg", 17'h00, 17'(v));
        rd(10'h301, v);
        chk("unmapped", 17'h00, 17'(v));
        wr(10'h305, 8'hD0);
        rd(10'h305, v);
        chk("adjust rw", 17'hD0, 17'(v));
        $display("test regs done");
        // every range code under both directions and two offsets
        for (int k = 0; k < 4; k++) begin
            off = k[1] ? 3'h6 : 3'h0;
            wr(10'h305, {off, k[0], 4'h0});
            for (int r = 0; r < 8; r++) begin
                c = r[0] ? 12'h9A5 : 12'h35C;
                put(c, 3'(r), 1'b1);
                exp_q.push_back(scl(c, 3'(r), off, k[0], 1'b1));
            end
            drain("shift");
        end
        wr(10'h305, 8'h00);
        put(12'h111, 3'h2, 1'b0);
        put(12'h222, 3'h3, 1'b0);
        put(12'h123, 3'h1, 1'b1);
        exp_q.push_back(scl(12'h123, 3'h1, 3'h0, 1'b0, 1'b1));
        drain("enable");
        wr(10'h300, 8'h01);
        chk("mode pin", 17'(AIPS_DIVERSITY), 17'(mode));
        hold = 1'b1;
        for (int i = 0; i < 6; i++) begin
            c = 12'h400 + 12'(i);
            put(c, 3'h0, (i == 0 || i == 1 || i == 4));
            if (i != 1 && i != 3)
                exp_q.push_back(scl(c, 3'h0, 3'h0, 1'b0, (i == 0 || i == 4)));
        end
        drain("diversity");
        hold = 1'b0;
        wr(10'h300, 8'h03);
        rd(10'h300, v);
        chk("mode 11", 17'h01, 17'(v));
        wr(10'h300, 8'h02);
        chk("mode pin", 17'(AIPS_COMPLEX), 17'(mode));
        for (int i = 0; i < 4; i++) begin
            c = 12'h7F0 - 12'(i);
            put(c, 3'h1, ~i[0]);
            exp_q.push_back(scl(c, 3'h1, 3'h0, 1'b0, ~i[0]));
        end
        drain("complex");
        // stalled receiver: buffer fills, later words are flagged
        wr(10'h300, 8'h00);
        out_ready = 1'b0;
        for (int i = 0; i < 6; i++) begin
            put(12'h050, 3'h0, 1'b1);
        end
        idle(4);
        chk("in ready", 17'h0, 17'(in_ready));
        chk("overflow", 17'h1, 17'(overflow));
        rd(10'h300, v);
        chk("ovf reg", 17'h80, 17'(v));
        wr(10'h300, 8'h80);
        idle(1);
        chk("ovf clear", 17'h0, 17'(overflow));
        out_ready = 1'b1;
        idle(6);
        chk("in ready", 17'h1, 17'(in_ready));
        // the two parked words leave in order, each exactly once
        exp_q.push_back(scl(12'h050, 3'h0, 3'h0, 1'b0, 1'b1));
        exp_q.push_back(scl(12'h050, 3'h0, 3'h0, 1'b0, 1'b1));
        drain("overflow");
        // low enable freezes a captured word until enable returns
        put(12'hC31, 3'h2, 1'b1);
        idle(1);
        ce = 1'b0;
        idle(8);
        chk("frozen out", 17'h0, 17'(got_q.size()));
        chk("frozen valid", 17'h0, 17'(out_valid));
        ce = 1'b1;
        exp_q.push_back(scl(12'hC31, 3'h2, 3'h0, 1'b0, 1'b1));
        drain("freeze");
        complete_run();
    end
endmodule
`default_nettype wire
